// ### dv/swpc_top_asserts.sv
// Concurrent checks on the ports of the sleep/wake sequencer top.
// Assumes it is bound into swpc_top; one clock domain, sys_clk.
`timescale 1ns/100ps
`include "swpc_map.svh"
module swpc_top_asserts
  import swpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Stimulus seen
  input wire logic wdt_perm,
  input wire logic wdt_rc_src,
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic irq_taken,
  input wire logic wdt_timeout,
  input wire logic reg_bank_f,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  // Outputs watched
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_clk_en,
  input wire logic osc_enable,
  input wire logic exec_hold,
  input wire logic restart_req,
  input wire logic [15:0] restart_pc,
  input wire logic wdt_run,
  input wire logic [3:0] port_low_emi,
  input wire logic osc_low_emi
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // A watchdog hit in the same cycle takes priority, so it is excluded
  sequence s_halt_op;
    instr_valid && instr_opcode == `SWPC_OP_HALT && cpu_clk_en && !wdt_timeout;
  endsequence
  sequence s_stop_op;
    instr_valid && instr_opcode == `SWPC_OP_STOP && cpu_clk_en && !wdt_timeout;
  endsequence
  sequence s_halted;
    !cpu_clk_en && osc_enable && !exec_hold && !restart_req;
  endsequence
  sequence s_pdc_wr;
    reg_wr && reg_bank_f && reg_addr == `SWPC_OFS_PORT_DRIVE_CONFIG && cpu_clk_en && !wdt_timeout;
  endsequence
  AST_HALT_ENTRY: assert property (s_halt_op |=> cpu_clk_en ##1
    !cpu_clk_en && osc_enable)
    else $error("HALT opcode did not gate only the CPU clock");
  AST_STOP_ENTRY: assert property (s_stop_op |-> ##2
    !cpu_clk_en && !osc_enable)
    else $error("STOP opcode did not stop both clocks");
  AST_HALT_EXIT: assert property (s_halted ##0 irq_taken |-> ##2 cpu_clk_en)
    else $error("Taken interrupt did not end HALT");
  AST_STOP_NO_CPU: assert property (!osc_enable |-> !cpu_clk_en)
    else $error("CPU clock runs with oscillator off");
  AST_HOLD_NO_CPU: assert property (exec_hold |-> !cpu_clk_en)
    else $error("CPU clock runs during execution hold");
  AST_RESTART: assert property (restart_req |=> !restart_req ##[0:2]
    cpu_clk_en && !exec_hold)
    else $error("Restart pulse not followed by run");
  AST_RESTART_PC: assert property (restart_req |-> restart_pc == `SWPC_RESTART_PC)
    else $error("Restart address wrong");
  AST_WDT_STOP: assert property (!osc_enable && wdt_timeout |-> ##[1:3] exec_hold)
    else $error("Watchdog wake from STOP skipped the power-on delay");
  AST_WDT_PERM: assert property ((wdt_perm && !wdt_rc_src) [*4] |-> wdt_run)
    else $error("Permanent watchdog not running");
  AST_LOW_EMI: assert property (s_pdc_wr |=>
    port_low_emi == ~$past(reg_wdata[6:3]) && osc_low_emi == ~$past(reg_wdata[7]))
    else $error("Drive selects do not follow written config");
  AST_RD_WO: assert property (reg_rd |=> reg_rdata[6:0] == 7'h00)
    else $error("Write-only bits read back nonzero");
  AST_RD_PDC: assert property (reg_rd && reg_addr == `SWPC_OFS_PORT_DRIVE_CONFIG
    |=> reg_rdata == 8'h00)
    else $error("Port drive config read back nonzero");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data present without a read");
endmodule

// ### dv/tb.sv
// Self-checking bench for the sleep/wake sequencer and port drive config.
// Assumes swpc_top with a short power-on delay; the bench drives every port.
`timescale 1ns/100ps
`include "swpc_map.svh"
module tb
  import swpc_pkg::*;
;
  logic sys_clk, arst_n, pwr_good, ext_rst_n, rc_osc, wdt_perm, wdt_rc_src;
  logic instr_valid, irq_taken, wdt_timeout, wdt_halt_en, wdt_stop_en;
  logic reg_bank_f, reg_wr, reg_rd, p3_core_out_a, p3_core_out_b, rd_seen;
  logic cpu_clk_en, osc_enable, exec_hold, restart_req, wdt_run, sclk_div16, sclk_div2_off;
  logic comparator_out_pin_a, comparator_out_pin_b, osc_low_emi;
  logic [3:0] p3_in, reg_addr, port_low_emi;
  logic [7:0] p2_in, instr_opcode, reg_wdata, reg_rdata, p0_core_out, p0_core_oe;
  logic [7:0] p1_core_out, p1_core_oe, p0_pad_out, p0_pad_oe, p1_pad_out, p1_pad_oe;
  logic [1:0] comp_out;
  logic [15:0] restart_pc;
  logic [31:0] seed;
  logic [7:0] rq[$];
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int restarts = 0;

  // Short delay keeps each wake within a few dozen clocks
  swpc_top #(.POR_TICKS(4)) DUT (.sys_clk, .arst_n, .pwr_good, .ext_rst_n, .rc_osc, .wdt_perm,
    .wdt_rc_src, .p3_in, .p2_in, .instr_valid, .instr_opcode, .irq_taken, .wdt_timeout,
    .wdt_halt_en, .wdt_stop_en, .reg_bank_f, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .cpu_clk_en, .osc_enable, .exec_hold, .restart_req, .restart_pc, .wdt_run,
    .sclk_div16, .sclk_div2_off, .p0_core_out, .p0_core_oe, .p1_core_out, .p1_core_oe,
    .p0_pad_out, .p0_pad_oe, .p1_pad_out, .p1_pad_oe, .comp_out, .p3_core_out_a,
    .p3_core_out_b, .comparator_out_pin_a, .comparator_out_pin_b, .port_low_emi, .osc_low_emi);

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // On-chip RC oscillator runs free, unrelated to sys_clk
  initial
  begin
    rc_osc = 1'b0;
    forever #85 rc_osc = ~rc_osc;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic bf);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_bank_f <= bf;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_bank_f <= 1'b1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rq.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    tick(2);
  endtask
  task automatic op(input logic [7:0] c);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_opcode <= 8'hFF;
    @(posedge sys_clk);
    instr_opcode <= c;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
  endtask
  task automatic pulse(input logic w);
    @(posedge sys_clk);
    wdt_timeout <= w;
    irq_taken <= ~w;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    irq_taken <= 1'b0;
  endtask
  task automatic wait_run();
    int n;
    for (n = 0; n < 400 && cpu_clk_en !== 1'b1; n++)
      @(negedge sys_clk);
    chk("cpu_clk_en", 16'h0001, {15'h0000, cpu_clk_en});
  endtask
  task automatic port_chk(input logic [7:0] c);
    logic [7:0] oe0, oe1;
    @(posedge sys_clk);
    seed = lfsr(seed);
    {p0_core_out, p0_core_oe, p1_core_out, p1_core_oe} <= seed;
    comp_out <= seed[5:4];
    p3_core_out_a <= seed[9];
    p3_core_out_b <= seed[30];
    @(posedge sys_clk);
    @(negedge sys_clk);
    oe0 = c[2] ? p0_core_oe : p0_core_oe & ~p0_core_out;
    oe1 = c[1] ? p1_core_oe : p1_core_oe & ~p1_core_out;
    chk("p0_pad_oe", {8'h00, oe0}, {8'h00, p0_pad_oe});
    chk("p1_pad_oe", {8'h00, oe1}, {8'h00, p1_pad_oe});
    chk("p0_pad_out", {8'h00, p0_core_out & oe0}, {8'h00, p0_pad_out & p0_pad_oe});
    chk("p1_pad_out", {8'h00, p1_core_out & oe1}, {8'h00, p1_pad_out & p1_pad_oe});
    chk("comparator pins", {14'h0000, c[0] ? comp_out : {p3_core_out_b, p3_core_out_a}},
      {14'h0000, comparator_out_pin_b, comparator_out_pin_a});
    chk("drive selects", {11'h000, ~c[7:3]},
      {11'h000, osc_low_emi, port_low_emi});
  endtask

  // Read results land one cycle after the read strobe
  always @(posedge sys_clk)
  begin
    if (rd_seen === 1'b1 && rq.size() > 0)
      chk("reg_rdata", {8'h00, rq.pop_front()}, {8'h00, reg_rdata});
    rd_seen <= reg_rd;
    if (restart_req === 1'b1)
      restarts <= restarts + 1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    int i, src;
    logic [7:0] cfg, a2;
    logic [3:0] a3;
    logic pol, dly, seen;
    {arst_n, pwr_good, wdt_perm, wdt_rc_src, instr_valid, instr_opcode, irq_taken} = '0;
    {wdt_timeout, reg_addr, reg_wr, reg_rd, reg_wdata, p3_in, p2_in} = '0;
    {p0_core_out, p0_core_oe, p1_core_out, p1_core_oe, comp_out} = '0;
    {p3_core_out_a, p3_core_out_b} = 2'h0;
    {ext_rst_n, wdt_halt_en, wdt_stop_en, reg_bank_f} = 4'hF;
    seed = 32'h000180F9;
    tick(10);
    arst_n <= 1'b1;
    tick(3);
    pwr_good <= 1'b1;
    tick(4);
    @(negedge sys_clk);
    chk("exec_hold", 16'h0001, {15'h0000, exec_hold});
    wait_run();
    chk("restarts", 16'h0001, restarts[15:0]);
    rd(4'h0, 8'h00);
    rd(4'hB, 8'h00);
    port_chk(`SWPC_RST_PORT_DRIVE_CONFIG);
    for (i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      cfg = (i == 0) ? 8'h01 : seed[7:0];
      wr(4'h0, cfg, 1'b1);
      port_chk(cfg);
    end
    rd(4'h0, 8'h00);
    wr(4'h0, ~cfg, 1'b0);
    wr(4'h3, ~cfg, 1'b1);
    port_chk(cfg);
    @(posedge sys_clk);
    wdt_perm <= 1'b1;
    wdt_halt_en <= 1'b0;
    op(`SWPC_OP_HALT);
    tick(2);
    // A STOP opcode while halted must be ignored
    op(`SWPC_OP_STOP);
    tick(3);
    @(negedge sys_clk);
    chk("halt clocks", 16'h0001, {14'h0000, cpu_clk_en, osc_enable});
    chk("wdt_run", 16'h0001, {15'h0000, wdt_run});
    pulse(1'b0);
    wait_run();
    chk("restarts", 16'h0001, restarts[15:0]);
    @(posedge sys_clk);
    wdt_perm <= 1'b0;
    wdt_halt_en <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      pol = (i != 0);
      src = (i == 0) ? 1 : i;
      dly = i[0];
      a3 = (src < 5) ? 4'h1 << (src - 1) : 4'h0;
      a2 = (src == 5) ? 8'h80 : 8'h00;
      @(posedge sys_clk);
      p3_in <= pol ? 4'h0 : 4'hF;
      p2_in <= (src > 5) ? 8'hFF : 8'h00;
      wr(4'hB, {1'b0, pol, dly, src[2:0], 2'b00}, 1'b1);
      op(`SWPC_OP_STOP);
      tick(8);
      @(negedge sys_clk);
      chk("stopped", 16'h0000, {14'h0000, cpu_clk_en, osc_enable});
      @(posedge sys_clk);
      p3_in <= pol ? a3 : ~a3;
      p2_in <= a2;
      seen = 1'b0;
      repeat (7)
      begin
        @(negedge sys_clk);
        seen = seen | exec_hold;
      end
      wait_run();
      chk("delay applied", {15'h0000, dly}, {15'h0000, seen});
      chk("restarts", 16'(i + 2), restarts[15:0]);
      rd(4'hB, 8'h80);
    end
    @(posedge sys_clk);
    p3_in <= 4'hF;
    wr(4'h0, 8'h5A, 1'b1);
    wr(4'hB, 8'h07, 1'b1);
    op(`SWPC_OP_STOP);
    tick(4);
    pulse(1'b1);
    tick(2);
    @(negedge sys_clk);
    chk("exec_hold", 16'h0001, {15'h0000, exec_hold});
    wait_run();
    rd(4'hB, 8'h00);
    port_chk(8'h5A);
    chk("div", 16'h2, {14'h0, sclk_div2_off, sclk_div16});
    pulse(1'b1);
    wait_run();
    port_chk(`SWPC_RST_PORT_DRIVE_CONFIG);
    @(posedge sys_clk);
    ext_rst_n <= 1'b0;
    tick(4);
    ext_rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("exec_hold", 16'h1, {15'h0, exec_hold});
    wait_run();
    tally_and_finish();
  end
endmodule

bind swpc_top swpc_top_asserts u_asserts (.sys_clk, .arst_n, .wdt_perm, .wdt_rc_src,
  .instr_valid, .instr_opcode, .irq_taken, .wdt_timeout, .reg_bank_f, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .cpu_clk_en, .osc_enable, .exec_hold, .restart_req,
  .restart_pc, .wdt_run, .port_low_emi, .osc_low_emi);

// ### logic/swpc_por_timer.sv
// One-shot power-on delay timer counting RC oscillator edges.
// Assumes rc_level is already synchronised to sys_clk.
`timescale 1ns/100ps
`include "swpc_map.svh"
module swpc_por_timer
  import swpc_pkg::*;
#(
  parameter int TICKS = `SWPC_POR_RC_TICKS,
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic rc_level,
  // Status
  output logic busy
);

  logic run_ff;
  logic nxt_run;
  logic rc_prev_ff;
  logic nxt_rc_prev;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic rc_rise;

  assign rc_rise = rc_level & ~rc_prev_ff;
  // Start counts as busy at once so the sequencer never sees a gap
  assign busy = run_ff | start;

  always_comb
  begin
    nxt_rc_prev = rc_level;
    nxt_run = run_ff;
    nxt_cnt = cnt_ff;
    if (start)
    begin
      // Retrigger restarts the full delay
      nxt_run = 1'b1;
      nxt_cnt = CNT_W'(TICKS);
    end
    else if (run_ff && rc_rise)
    begin
      nxt_cnt = cnt_ff - CNT_W'(1);
      if (cnt_ff <= CNT_W'(1))
      begin
        nxt_run = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_ff <= 1'b0;
      rc_prev_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else
    begin
      run_ff <= nxt_run;
      rc_prev_ff <= nxt_rc_prev;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ### logic/swpc_top.sv
// Sleep/wake sequencer, power-on delay and port drive configuration.
// Assumes a core that reports decoded opcodes and granted interrupts on
// sys_clk, and pads, straps and RC oscillator arriving asynchronously.
//
// Behaviour
// RULE_01 - Power-on delay is a one-shot on RC clock, three trigger causes.
// RULE_02 - Instruction execution is held off while the power-on delay runs.
// RULE_03 - HALT gates CPU clock; oscillator, timers, external interrupts keep running.
// RULE_04 - HALT ends on a taken enabled interrupt; execution resumes after HALT.
// RULE_05 - Software places a no-operation right before each sleep instruction.
// RULE_06 - One opcode enters STOP, another opcode enters HALT.
// RULE_07 - STOP halts internal clock and crystal oscillator.
// RULE_08 - STOP ends only by a reset cause; restart at fixed address.
// RULE_09 - Watchdog wake from STOP keeps registers but always applies power-on delay.
// RULE_10 - Permanent watchdog on RC clock runs in every mode, never stoppable.
// RULE_11 - Config bit 0 routes comparator outputs to two Port 3 pins; default 0.
// RULE_12 - Config bit 1 clear makes Port 1 open-drain; default 1.
// RULE_13 - Config bit 2 clear makes Port 0 open-drain; default 1.
// RULE_14 - Config bits 3..6 clear give low-EMI drive on Ports 0..3; default 1.
// RULE_15 - Config bit 7 clear gives low-noise oscillator and strobe drive; default 1.
// RULE_16 - Small-package software keeps Port 1 drive bits set.
// RULE_17 - Port drive config is write-only at bank F location 0.
// RULE_18 - Stop wake config is write-only except read-only warm flag bit 7.
// RULE_19 - Stop wake bit 6 picks low or high wake level.
// RULE_20 - Stop wake bits 2..4 pick source; register at bank F location 11.
// RULE_21 - Without delay, the wake source stays active at least five clocks.
// RULE_22 - Warm flag reads one after recovery wake, zero after power-on or watchdog.
// RULE_23 - Wake polarity defaults to zero, low level wakes.
// RULE_24 - Power-on loads every port config bit with its default.
`timescale 1ns/100ps
`include "swpc_map.svh"
module swpc_top
  import swpc_pkg::*;
#(
  parameter int POR_TICKS = `SWPC_POR_RC_TICKS
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Asynchronous pins and straps
  input wire logic pwr_good,
  input wire logic ext_rst_n,
  input wire logic rc_osc,
  input wire logic wdt_perm,
  input wire logic wdt_rc_src,
  input wire logic [3:0] p3_in,
  input wire logic [7:0] p2_in,
  // Core side, same clock
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic irq_taken,
  input wire logic wdt_timeout,
  input wire logic wdt_halt_en,
  input wire logic wdt_stop_en,
  // Expanded register bank F access
  input wire logic reg_bank_f,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Clock and execution control
  output logic cpu_clk_en,
  output logic osc_enable,
  output logic exec_hold,
  output logic restart_req,
  output logic [15:0] restart_pc,
  output logic wdt_run,
  output logic sclk_div16,
  output logic sclk_div2_off,
  // Port 0 and Port 1 drivers
  input wire logic [7:0] p0_core_out,
  input wire logic [7:0] p0_core_oe,
  input wire logic [7:0] p1_core_out,
  input wire logic [7:0] p1_core_oe,
  output logic [7:0] p0_pad_out,
  output logic [7:0] p0_pad_oe,
  output logic [7:0] p1_pad_out,
  output logic [7:0] p1_pad_oe,
  // Comparator routing on Port 3
  input wire logic [1:0] comp_out,
  input wire logic p3_core_out_a,
  input wire logic p3_core_out_b,
  output logic comparator_out_pin_a,
  output logic comparator_out_pin_b,
  // Drive strength selects
  output logic [3:0] port_low_emi,
  output logic osc_low_emi
);

  localparam swpc_pdc_t PDC_RST = `SWPC_RST_PORT_DRIVE_CONFIG;
  localparam swpc_swc_t SWC_RST = `SWPC_RST_STOP_WAKE_CONFIG;

  // Open-drain keeps only the low drive; a high is left to the pull-up
  function automatic logic [7:0] pad_oe(input logic [7:0] dout, input logic [7:0] oe,
                                        input logic push_pull);
    pad_oe = push_pull ? oe : (oe & ~dout);
  endfunction

  // Two-flop synchroniser for every asynchronous input
  swpc_pins_t raw_pins;
  swpc_pins_t sync1_ff;
  swpc_pins_t sync2_ff;
  swpc_pins_t nxt_sync1;
  swpc_pins_t nxt_sync2;

  assign raw_pins = '{pwr_good: pwr_good, ext_rst_n: ext_rst_n, wdt_perm: wdt_perm,
                      wdt_rc_src: wdt_rc_src, rc_osc: rc_osc, p3_in: p3_in,
                      p2_in: p2_in};

  always_comb
  begin
    nxt_sync1 = raw_pins;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // Power-good edge detect on the synchronised level
  logic pg_prev_ff;
  logic nxt_pg_prev;
  logic pg_rise;
  logic por_start;
  logic por_busy;

  assign pg_rise = sync2_ff.pwr_good & ~pg_prev_ff;

  // Sequencer and configuration registers
  swpc_state_t state_ff;
  swpc_state_t nxt_state;
  swpc_pdc_t pdc_ff;
  swpc_pdc_t nxt_pdc;
  swpc_swc_t smr_ff;
  swpc_swc_t nxt_smr;
  logic restart_ff;
  logic nxt_restart;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic wr_pdc;
  logic wr_smr;

  // Selected wake source level, compared against the chosen polarity
  logic src_level;
  logic wake_hit;

  always_comb
  begin
    unique case (smr_ff.src)
      `SWPC_SRC_NONE: src_level = ~smr_ff.wake_high;
      `SWPC_SRC_P30: src_level = sync2_ff.p3_in[0];
      `SWPC_SRC_P31: src_level = sync2_ff.p3_in[1];
      `SWPC_SRC_P32: src_level = sync2_ff.p3_in[2];
      `SWPC_SRC_P33: src_level = sync2_ff.p3_in[3];
      `SWPC_SRC_P27: src_level = sync2_ff.p2_in[7];
      `SWPC_SRC_NOR_LO: src_level = ~|sync2_ff.p2_in[3:0];
      `SWPC_SRC_NOR_ALL: src_level = ~|sync2_ff.p2_in;
    endcase
  end

  // Code 0 never wakes; only reset causes end STOP then
  assign wake_hit = (smr_ff.src != `SWPC_SRC_NONE) &&
                    (src_level == smr_ff.wake_high); // RULE_19 RULE_20

  assign wr_pdc = reg_wr && reg_bank_f && (reg_addr == `SWPC_OFS_PORT_DRIVE_CONFIG);
  assign wr_smr = reg_wr && reg_bank_f && (reg_addr == `SWPC_OFS_STOP_WAKE_CONFIG);

  always_comb
  begin
    nxt_pg_prev = sync2_ff.pwr_good;
    nxt_state = state_ff;
    nxt_pdc = pdc_ff;
    nxt_smr = smr_ff;
    nxt_restart = 1'b0;
    por_start = 1'b0;
    if (!sync2_ff.pwr_good || pg_rise)
    begin
      // Power-fail to good starts the one-shot
      por_start = pg_rise; // RULE_01
      nxt_state = SWPC_DELAY;
      nxt_pdc = PDC_RST; // RULE_24
      nxt_smr = SWC_RST; // RULE_23
    end
    else if (!sync2_ff.ext_rst_n)
    begin
      nxt_state = SWPC_EXTRST; // RULE_08
      nxt_pdc = PDC_RST;
      nxt_smr = SWC_RST;
    end
    else
    begin
      unique case (state_ff)
        SWPC_DELAY:
        begin
          if (!por_busy)
          begin
            nxt_state = SWPC_RUN; // RULE_02
            nxt_restart = 1'b1;
          end
        end
        SWPC_EXTRST:
        begin
          nxt_state = SWPC_RUN;
          nxt_restart = 1'b1;
        end
        SWPC_RUN:
        begin
          if (wdt_timeout)
          begin
            por_start = 1'b1; // RULE_01
            nxt_state = SWPC_DELAY;
            nxt_pdc = PDC_RST;
            nxt_smr = SWC_RST;
          end
          else
          begin
            if (wr_pdc)
            begin
              nxt_pdc = swpc_pdc_t'(reg_wdata); // RULE_17
            end
            if (wr_smr)
            begin
              // Flag bit is not writable
              nxt_smr = swpc_swc_t'({smr_ff.warm, reg_wdata[6:0]}); // RULE_18
            end
            if (instr_valid && instr_opcode == `SWPC_OP_STOP)
            begin
              nxt_state = SWPC_STOP; // RULE_06
              nxt_smr.warm = 1'b1;
            end
            else if (instr_valid && instr_opcode == `SWPC_OP_HALT)
            begin
              nxt_state = SWPC_HALT; // RULE_06
            end
          end
        end
        SWPC_HALT:
        begin
          if (wdt_timeout)
          begin
            por_start = 1'b1;
            nxt_state = SWPC_DELAY;
            nxt_pdc = PDC_RST;
            nxt_smr = SWC_RST;
          end
          else if (irq_taken)
          begin
            // Core keeps its PC, so service returns past the HALT
            nxt_state = SWPC_RUN; // RULE_04
          end
        end
        SWPC_STOP:
        begin
          if (wdt_timeout)
          begin
            // Configuration survives except div16 and the warm flag; delay applied regardless of delay bit
            por_start = 1'b1; // RULE_09
            nxt_state = SWPC_DELAY;
            nxt_smr.warm = 1'b0; // RULE_22
            nxt_smr.div16 = 1'b0;
          end
          else if (wake_hit)
          begin
            nxt_smr.warm = 1'b1; // RULE_22
            nxt_smr.div16 = 1'b0;
            if (smr_ff.delay_en)
            begin
              por_start = 1'b1; // RULE_01
              nxt_state = SWPC_DELAY;
            end
            else
            begin
              // Single sample is enough since the source is held long
              nxt_state = SWPC_RUN; // RULE_21
              nxt_restart = 1'b1; // RULE_08
            end
          end
        end
      endcase
    end
    // Write-only locations read back zero; only the warm flag is visible
    nxt_rdata = 8'h00;
    if (reg_rd && reg_bank_f && reg_addr == `SWPC_OFS_STOP_WAKE_CONFIG)
    begin
      nxt_rdata = {smr_ff.warm, 7'h00}; // RULE_18
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pg_prev_ff <= 1'b0;
      state_ff <= SWPC_DELAY;
      pdc_ff <= PDC_RST; // RULE_24
      smr_ff <= SWC_RST;
      restart_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      pg_prev_ff <= nxt_pg_prev;
      state_ff <= nxt_state;
      pdc_ff <= nxt_pdc;
      smr_ff <= nxt_smr;
      restart_ff <= nxt_restart;
      rdata_ff <= nxt_rdata;
    end
  end

  swpc_por_timer #(
    .TICKS(POR_TICKS),
    .CNT_W(16)
  ) u_por_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(por_start),
    .rc_level(sync2_ff.rc_osc),
    .busy(por_busy)
  );

  // Clock control and pad outputs, all registered
  logic clk_en_ff;
  logic osc_en_ff;
  logic hold_ff;
  logic wdt_run_ff;
  logic nxt_clk_en;
  logic nxt_osc_en;
  logic nxt_hold;
  logic nxt_wdt_run;
  logic [7:0] p0_out_ff;
  logic [7:0] p0_oe_ff;
  logic [7:0] p1_out_ff;
  logic [7:0] p1_oe_ff;
  logic [7:0] nxt_p0_oe;
  logic [7:0] nxt_p1_oe;
  logic cmp_a_ff;
  logic cmp_b_ff;
  logic nxt_cmp_a;
  logic nxt_cmp_b;

  always_comb
  begin
    // Oscillator and timers run in HALT; only the CPU clock is gated
    nxt_clk_en = (state_ff == SWPC_RUN); // RULE_03
    nxt_osc_en = (state_ff != SWPC_STOP); // RULE_07
    nxt_hold = (state_ff == SWPC_DELAY) || (state_ff == SWPC_EXTRST); // RULE_02
    if (sync2_ff.wdt_perm && !sync2_ff.wdt_rc_src)
    begin
      nxt_wdt_run = 1'b1; // RULE_10
    end
    else if (state_ff == SWPC_HALT)
    begin
      nxt_wdt_run = wdt_halt_en;
    end
    else if (state_ff == SWPC_STOP)
    begin
      nxt_wdt_run = wdt_stop_en;
    end
    else
    begin
      nxt_wdt_run = 1'b1;
    end
    nxt_p0_oe = pad_oe(p0_core_out, p0_core_oe, pdc_ff.p0_pp); // RULE_13
    nxt_p1_oe = pad_oe(p1_core_out, p1_core_oe, pdc_ff.p1_pp); // RULE_12
    nxt_cmp_a = pdc_ff.comp_route ? comp_out[0] : p3_core_out_a; // RULE_11
    nxt_cmp_b = pdc_ff.comp_route ? comp_out[1] : p3_core_out_b; // RULE_11
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_en_ff <= 1'b0;
      osc_en_ff <= 1'b1;
      hold_ff <= 1'b1;
      wdt_run_ff <= 1'b0;
      p0_out_ff <= 8'h00;
      p0_oe_ff <= 8'h00;
      p1_out_ff <= 8'h00;
      p1_oe_ff <= 8'h00;
      cmp_a_ff <= 1'b0;
      cmp_b_ff <= 1'b0;
    end
    else
    begin
      clk_en_ff <= nxt_clk_en;
      osc_en_ff <= nxt_osc_en;
      hold_ff <= nxt_hold;
      wdt_run_ff <= nxt_wdt_run;
      p0_out_ff <= p0_core_out;
      p0_oe_ff <= nxt_p0_oe;
      p1_out_ff <= p1_core_out;
      p1_oe_ff <= nxt_p1_oe;
      cmp_a_ff <= nxt_cmp_a;
      cmp_b_ff <= nxt_cmp_b;
    end
  end

  assign cpu_clk_en = clk_en_ff;
  assign osc_enable = osc_en_ff;
  assign exec_hold = hold_ff;
  assign restart_req = restart_ff;
  assign restart_pc = `SWPC_RESTART_PC; // RULE_08
  assign wdt_run = wdt_run_ff;
  assign sclk_div16 = smr_ff.div16;
  assign sclk_div2_off = smr_ff.div2_off;
  assign reg_rdata = rdata_ff;
  assign p0_pad_out = p0_out_ff;
  assign p0_pad_oe = p0_oe_ff;
  assign p1_pad_out = p1_out_ff;
  assign p1_pad_oe = p1_oe_ff;
  assign comparator_out_pin_a = cmp_a_ff;
  assign comparator_out_pin_b = cmp_b_ff;
  // Inverted because a cleared bit selects the reduced drive
  assign port_low_emi = ~{pdc_ff.p3_std, pdc_ff.p2_std, pdc_ff.p1_std,
                          pdc_ff.p0_std}; // RULE_14
  assign osc_low_emi = ~pdc_ff.osc_std; // RULE_15

endmodule

// ### pkg/swpc_map.svh
// Constants of the sleep, wake and port configuration block.
// Included by the design modules and the bench files; definitions only.
`ifndef SWPC_MAP_SVH
`define SWPC_MAP_SVH

// Expanded register bank F locations
`define SWPC_OFS_PORT_DRIVE_CONFIG 4'h0
`define SWPC_OFS_STOP_WAKE_CONFIG 4'hB

// Reset values
`define SWPC_RST_PORT_DRIVE_CONFIG 8'hFE
`define SWPC_RST_STOP_WAKE_CONFIG 8'h20

// Port drive config field positions
`define SWPC_PDC_COMP_ROUTE 0
`define SWPC_PDC_P1_PUSH_PULL 1
`define SWPC_PDC_P0_PUSH_PULL 2
`define SWPC_PDC_P0_STD_DRIVE 3
`define SWPC_PDC_P3_STD_DRIVE 6
`define SWPC_PDC_OSC_STD_DRIVE 7

// Stop wake config field positions
`define SWPC_SWC_DIV16 0
`define SWPC_SWC_SRC_LO 2
`define SWPC_SWC_SRC_HI 4
`define SWPC_SWC_DELAY_EN 5
`define SWPC_SWC_WAKE_HIGH 6
`define SWPC_SWC_WARM 7

// Sleep opcodes and restart address
`define SWPC_OP_STOP 8'h6F
`define SWPC_OP_HALT 8'h7F
`define SWPC_RESTART_PC 16'h000C

// Wake source selector codes
`define SWPC_SRC_NONE 3'h0
`define SWPC_SRC_P30 3'h1
`define SWPC_SRC_P31 3'h2
`define SWPC_SRC_P32 3'h3
`define SWPC_SRC_P33 3'h4
`define SWPC_SRC_P27 3'h5
`define SWPC_SRC_NOR_LO 3'h6
`define SWPC_SRC_NOR_ALL 3'h7

// Power-on delay length in rising edges of the RC oscillator
`define SWPC_POR_RC_TICKS 16

`endif

// ### pkg/swpc_pkg.sv
// Types of the sleep, wake and port configuration block.
// Field layouts follow the positions in swpc_map.svh.
package swpc_pkg;

  typedef struct packed {
    logic osc_std;
    logic p3_std;
    logic p2_std;
    logic p1_std;
    logic p0_std;
    logic p0_pp;
    logic p1_pp;
    logic comp_route;
  } swpc_pdc_t;

  typedef struct packed {
    logic warm;
    logic wake_high;
    logic delay_en;
    logic [2:0] src;
    logic div2_off;
    logic div16;
  } swpc_swc_t;

  typedef struct packed {
    logic pwr_good;
    logic ext_rst_n;
    logic wdt_perm;
    logic wdt_rc_src;
    logic rc_osc;
    logic [3:0] p3_in;
    logic [7:0] p2_in;
  } swpc_pins_t;

  typedef enum logic [2:0] {
    SWPC_DELAY = 3'b000,
    SWPC_RUN = 3'b001,
    SWPC_HALT = 3'b010,
    SWPC_STOP = 3'b011,
    SWPC_EXTRST = 3'b100
  } swpc_state_t;

endpackage
